// ==== rtl/rss_top.sv ====
// Return address stack with fault flags, fault reset and fast shadow registers
// Operation
// - Push increments pointer, stores current PC
// - Top entry readable, writable as three bytes
// - Pop decrements pointer, previous entry becomes top
// - Fault reset enable from configuration bit
// - Enable clear: fault only sets flag
// - Enable set: flag first, then reset
// - Flags sticky until software or power-on
// - Full and underflow recorded as reset causes
// - One hidden shadow level per register
// - Interrupt vectoring captures all three registers
// - Fast interrupt return restores shadow values
// - Later interrupt overwrites shadow, no nesting
// - Fast call saves registers into shadow
// - Fast return restores registers from shadow
`timescale 1ns/1ps
module rss_top (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Instruction sequencer
  input wire logic [rss_pkg::PC_W-1:0] pc,
  input wire logic push_op,
  input wire logic pop_op,
  input wire logic call_op,
  input wire logic ret_op,
  input wire logic return_from_interrupt,
  input wire logic fast_opt,
  input wire logic irq_vector,
  // Core registers to shadow
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_register,
  input wire logic [7:0] bank_select_register,
  // Shadow restore
  output logic restore_en,
  output logic [7:0] restore_status,
  output logic [7:0] restore_working,
  output logic [7:0] restore_bank,
  // Return address
  output logic [rss_pkg::PC_W-1:0] top_of_stack,
  // Configuration and resets
  input wire logic stack_fault_reset_enable,
  input wire logic pin_rst,
  input wire logic wdt_rst,
  input wire logic bor_rst,
  input wire logic inst_rst,
  output logic stack_reset_req,
  output logic stack_full_flag,
  output logic stack_underflow_flag,
  output logic irq
);

  rss_pkg::rss_state_s st_r;
  rss_pkg::rss_state_s st_nxt;
  logic [rss_pkg::PC_W-1:0] mem [rss_pkg::STK_DEPTH];
  logic push_req;
  logic pop_req;
  logic ev_full;
  logic ev_unf;
  logic other_rst;
  logic [rss_pkg::PTR_W-1:0] top_idx;
  logic top_valid;
  logic [7:0] ctl_byte;

  // Operation decode
  assign push_req = (push_op | call_op) & ~st_r.pend;
  assign pop_req = (pop_op | ret_op | return_from_interrupt) & ~st_r.pend & ~push_req;
  assign ev_full = push_req & (st_r.ptr == rss_pkg::PTR_FULL);
  assign ev_unf = pop_req & (st_r.ptr == rss_pkg::PTR_EMPTY);
  assign other_rst = pin_rst | wdt_rst | bor_rst | inst_rst;
  assign top_valid = st_r.ptr != rss_pkg::PTR_EMPTY;
  assign top_idx = st_r.ptr - rss_pkg::PTR_ONE;
  assign ctl_byte = {st_r.full, st_r.unf, 1'b0, st_r.ptr};

  // Top entry, zero when the stack is empty
  assign top_of_stack = top_valid ? mem[top_idx] : '0;

  // Stack entries; a faulting push writes nothing
  always_ff @(posedge sys_clk) begin
    if (push_req && !ev_full) begin
      mem[st_r.ptr] <= pc;
    end else if (reg_we && top_valid) begin
      unique case (reg_addr)
        rss_pkg::ADDR_TOP_UPPER: begin
          mem[top_idx][rss_pkg::PC_W-1:16] <= reg_wdata[rss_pkg::UPPER_W-1:0];
        end
        rss_pkg::ADDR_TOP_HIGH: begin
          mem[top_idx][15:8] <= reg_wdata;
        end
        rss_pkg::ADDR_TOP_LOW: begin
          mem[top_idx][7:0] <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.fault_rst = 1'b0;
    st_nxt.rdata = rss_pkg::RST_BYTE;
    // Pointer movement, held at the ends on a fault
    if (push_req && !ev_full) begin
      st_nxt.ptr = st_r.ptr + rss_pkg::PTR_ONE;
    end else if (pop_req && !ev_unf) begin
      st_nxt.ptr = st_r.ptr - rss_pkg::PTR_ONE;
    end
    // Software clears flags by writing ones; a new fault wins
    if (reg_we && reg_addr == rss_pkg::ADDR_STK_CTL) begin
      if (reg_wdata[rss_pkg::CTL_FULL_BIT]) st_nxt.full = 1'b0;
      if (reg_wdata[rss_pkg::CTL_UNF_BIT]) st_nxt.unf = 1'b0;
    end
    if (reg_we && reg_addr == rss_pkg::ADDR_INT_STAT) begin
      st_nxt.ist = st_r.ist & ~reg_wdata[1:0];
    end
    if (reg_we && reg_addr == rss_pkg::ADDR_INT_MASK) begin
      st_nxt.imask = reg_wdata[1:0];
    end
    if (ev_full) begin
      st_nxt.full = 1'b1;
      st_nxt.ist[rss_pkg::IST_FULL_BIT] = 1'b1;
    end
    if (ev_unf) begin
      st_nxt.unf = 1'b1;
      st_nxt.ist[rss_pkg::IST_UNF_BIT] = 1'b1;
    end
    // Fault reset follows the flag by one cycle when enabled
    if ((ev_full || ev_unf) && stack_fault_reset_enable) begin
      st_nxt.pend = 1'b1;
      st_nxt.pend_full = ev_full;
    end
    if (st_r.pend) begin
      st_nxt.pend = 1'b0;
      st_nxt.fault_rst = 1'b1;
      st_nxt.ptr = rss_pkg::PTR_EMPTY;
      st_nxt.cause = st_r.pend_full ? rss_pkg::RC_FULL : rss_pkg::RC_UNF;
    end else if (other_rst) begin
      // Device resets other than power-on keep the flags
      st_nxt.ptr = rss_pkg::PTR_EMPTY;
      st_nxt.pend = 1'b0;
      if (pin_rst) st_nxt.cause = rss_pkg::RC_PIN;
      else if (wdt_rst) st_nxt.cause = rss_pkg::RC_WDT;
      else if (bor_rst) st_nxt.cause = rss_pkg::RC_BOR;
      else st_nxt.cause = rss_pkg::RC_INST;
    end
    // Shadow capture; a later capture simply overwrites
    if (irq_vector || (call_op && fast_opt)) begin
      st_nxt.sh_status = status_in;
      st_nxt.sh_working = working_register;
      st_nxt.sh_bank = bank_select_register;
    end
    // Read data for the cycle after the strobe
    if (reg_re) begin
      unique case (reg_addr)
        rss_pkg::ADDR_TOP_UPPER: st_nxt.rdata = {3'h0, top_of_stack[rss_pkg::PC_W-1:16]};
        rss_pkg::ADDR_TOP_HIGH: st_nxt.rdata = top_of_stack[15:8];
        rss_pkg::ADDR_TOP_LOW: st_nxt.rdata = top_of_stack[7:0];
        rss_pkg::ADDR_STK_CTL: st_nxt.rdata = ctl_byte;
        rss_pkg::ADDR_INT_STAT: st_nxt.rdata = {6'h00, st_r.ist};
        rss_pkg::ADDR_INT_MASK: st_nxt.rdata = {6'h00, st_r.imask};
        rss_pkg::ADDR_RST_CAUSE: st_nxt.rdata = {5'h00, st_r.cause};
        default: st_nxt.rdata = rss_pkg::RST_BYTE;
      endcase
    end
  end

  // State register; power-on clears everything
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '{ptr: rss_pkg::PTR_EMPTY, full: 1'b0, unf: 1'b0, ist: rss_pkg::RST_INT,
                imask: rss_pkg::RST_INT, cause: rss_pkg::RC_POR, pend: 1'b0,
                pend_full: 1'b0, fault_rst: 1'b0, rdata: rss_pkg::RST_BYTE,
                sh_status: rss_pkg::RST_BYTE, sh_working: rss_pkg::RST_BYTE,
                sh_bank: rss_pkg::RST_BYTE};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata = st_r.rdata;
  assign restore_en = (ret_op | return_from_interrupt) & fast_opt;
  assign restore_status = st_r.sh_status;
  assign restore_working = st_r.sh_working;
  assign restore_bank = st_r.sh_bank;
  assign stack_reset_req = st_r.fault_rst;
  assign stack_full_flag = st_r.full;
  assign stack_underflow_flag = st_r.unf;
  assign irq = |(st_r.ist & st_r.imask);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_fault_ev;
    (ev_full || ev_unf) && stack_fault_reset_enable;
  endsequence

  sequence s_flag_then_reset;
    (st_r.full || st_r.unf) && !stack_reset_req ##1 stack_reset_req ##1 !stack_reset_req;
  endsequence

  a_push_ptr_inc: assert property (
    push_req && !ev_full && !other_rst |=> st_r.ptr == $past(st_r.ptr) + rss_pkg::PTR_ONE)
    else $error("push did not advance pointer");

  a_push_top_pc: assert property (
    push_req && !ev_full && !other_rst |=> top_of_stack == $past(pc))
    else $error("push did not store pc");

  a_pop_ptr_dec: assert property (
    pop_req && !ev_unf && !other_rst |=> st_r.ptr == $past(st_r.ptr) - rss_pkg::PTR_ONE)
    else $error("pop did not drop entry");

  a_full_no_wrap: assert property (
    ev_full && !other_rst |=> st_r.full && st_r.ptr == rss_pkg::PTR_FULL)
    else $error("full fault flag or pointer wrong");

  a_unf_no_wrap: assert property (
    ev_unf && !other_rst |=> st_r.unf && st_r.ptr == rss_pkg::PTR_EMPTY)
    else $error("underflow fault flag or pointer wrong");

  a_fault_no_reset: assert property (
    (ev_full || ev_unf) && !stack_fault_reset_enable && !st_r.pend |=> !stack_reset_req [*2])
    else $error("fault reset without enable");

  a_fault_reset_seq: assert property (
    s_fault_ev |=> s_flag_then_reset)
    else $error("fault reset order wrong");

  a_flag_sticky: assert property (
    st_r.full && !(reg_we && reg_addr == rss_pkg::ADDR_STK_CTL) |=> st_r.full)
    else $error("full flag lost");

  a_cause_record: assert property (
    stack_reset_req |-> st_r.cause == rss_pkg::RC_FULL || st_r.cause == rss_pkg::RC_UNF)
    else $error("stack reset cause not recorded");

  a_shadow_capture: assert property (
    irq_vector |=> restore_working == $past(working_register) &&
      restore_bank == $past(bank_select_register))
    else $error("shadow not captured");

  a_fast_round_trip: assert property (
    call_op && fast_opt ##1 (ret_op && fast_opt && !irq_vector) |-> restore_en &&
      restore_status == $past(status_in))
    else $error("fast return lost saved status");

  // Register port, stack, fault, device reset, shadow and interrupt checks
  sequence s_capture;
    irq_vector || (call_op && fast_opt);
  endsequence

  a_top_write: assert property (
    reg_we && reg_addr == rss_pkg::ADDR_TOP_LOW && top_valid && !push_req && !pop_req &&
      !st_r.pend && !other_rst |=> top_of_stack[7:0] == $past(reg_wdata))
    else $error("top entry low byte not written");

  a_empty_top_zero: assert property (
    st_r.ptr == rss_pkg::PTR_EMPTY |-> top_of_stack == '0)
    else $error("empty stack shows an entry");

  a_full_keeps_top: assert property (
    ev_full && !other_rst |=> top_of_stack == $past(top_of_stack))
    else $error("full push corrupted top entry");

  a_fault_ptr_clear: assert property (
    stack_reset_req |-> st_r.ptr == rss_pkg::PTR_EMPTY)
    else $error("fault reset left pointer set");

  a_clear_full: assert property (
    reg_we && reg_addr == rss_pkg::ADDR_STK_CTL && reg_wdata[rss_pkg::CTL_FULL_BIT] && !ev_full
      |=> !st_r.full)
    else $error("full flag not cleared by software");

  a_unf_sticky: assert property (
    st_r.unf && !(reg_we && reg_addr == rss_pkg::ADDR_STK_CTL) |=> st_r.unf)
    else $error("underflow flag lost");

  a_other_keeps: assert property (
    other_rst && !st_r.pend && !ev_full && !ev_unf && !reg_we |=>
      st_r.full == $past(st_r.full) && st_r.unf == $past(st_r.unf))
    else $error("device reset cleared a stack flag");

  a_other_cause: assert property (
    other_rst && !st_r.pend |=> st_r.cause != rss_pkg::RC_FULL &&
      st_r.cause != rss_pkg::RC_UNF && st_r.cause != rss_pkg::RC_POR)
    else $error("device reset cause not recorded");

  a_shadow_status: assert property (
    s_capture |=> restore_status == $past(status_in) &&
      restore_working == $past(working_register))
    else $error("status not captured in shadow");

  a_restore_gate: assert property (
    (ret_op || return_from_interrupt) |-> restore_en == fast_opt)
    else $error("restore does not follow fast option");

  a_rdata_idle: assert property (
    !reg_re |=> reg_rdata == rss_pkg::RST_BYTE)
    else $error("read data stood too long");

  a_irq_raise: assert property (
    ev_unf && st_r.imask[rss_pkg::IST_UNF_BIT] && !reg_we |=> irq)
    else $error("underflow interrupt not raised");

endmodule // rss_top

// ==== rtl/rss_pkg.sv ====
// Constants, register map and state type of the return stack block
package rss_pkg;
  // Stack geometry
  localparam int STK_DEPTH = 31;
  localparam int PTR_W = 5;
  localparam int PC_W = 21;
  localparam logic [PTR_W-1:0] PTR_FULL = 5'h1f;
  localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
  localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
  // Register offsets
  localparam logic [3:0] ADDR_TOP_UPPER = 4'h0;
  localparam logic [3:0] ADDR_TOP_HIGH = 4'h1;
  localparam logic [3:0] ADDR_TOP_LOW = 4'h2;
  localparam logic [3:0] ADDR_STK_CTL = 4'h3;
  localparam logic [3:0] ADDR_INT_STAT = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_RST_CAUSE = 4'h6;
  // Field positions
  localparam int CTL_FULL_BIT = 7;
  localparam int CTL_UNF_BIT = 6;
  localparam int IST_FULL_BIT = 0;
  localparam int IST_UNF_BIT = 1;
  localparam int UPPER_W = 5;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_INT = 2'h0;
  // Reset causes
  typedef enum logic [2:0] {
    RC_POR, RC_PIN, RC_WDT, RC_BOR, RC_INST, RC_FULL, RC_UNF
  } rss_cause_e;
  // State of the block apart from the stack entries
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic full;
    logic unf;
    logic [1:0] ist;
    logic [1:0] imask;
    rss_cause_e cause;
    logic pend;
    logic pend_full;
    logic fault_rst;
    logic [7:0] rdata;
    logic [7:0] sh_status;
    logic [7:0] sh_working;
    logic [7:0] sh_bank;
  } rss_state_s;
endpackage

// ==== testbench/rss_core_model.sv ====
// Core register file that reloads from the shadow restore path
`timescale 1ns/1ps
module rss_core_model (
  // Clock
  input wire logic sys_clk,
  // Load from bench
  input wire logic ld,
  input wire logic [23:0] nv,
  // Restore path
  input wire logic restore_en,
  input wire logic [7:0] restore_status,
  input wire logic [7:0] restore_working,
  input wire logic [7:0] restore_bank,
  // Status, working and bank registers
  output logic [23:0] core
);
  // Restore wins over a bench load
  always_ff @(posedge sys_clk) begin
    if (restore_en) begin
      core <= {restore_status, restore_working, restore_bank};
    end else if (ld) begin
      core <= nv;
    end
  end
endmodule // rss_core_model

// ==== testbench/test_rss_top.sv ====
// Self-checking bench of the return stack block
`timescale 1ns/1ps
module test_rss_top;
  logic sys_clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, rd_d = 1'b0;
  logic en = 1'b0, fast = 1'b0, ld = 1'b0, restore_en, req, full_f, unf_f, irq;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rs, rw, rb;
  logic [9:0] ops = 10'h000; // push pop call ret rfi vec pin wdt bor inst
  logic [20:0] pc = 21'h0;
  logic [20:0] top_w;
  logic [23:0] nv = 24'h0, core, sv, ev;
  logic [31:0] seed = 32'h44a130a5;
  logic [20:0] stk[$];
  logic [7:0] exp_q[$];
  int num_checks = 0, miscompares = 0, cyc = 0, reqs = 0;
  always #5 sys_clk = ~sys_clk;
  rss_core_model u_core (.sys_clk(sys_clk), .ld(ld), .nv(nv), .restore_en(restore_en),
    .restore_status(rs), .restore_working(rw), .restore_bank(rb), .core(core));
  rss_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pc(pc), .push_op(ops[9]),
    .pop_op(ops[8]), .call_op(ops[7]), .ret_op(ops[6]), .return_from_interrupt(ops[5]),
    .fast_opt(fast), .irq_vector(ops[4]), .status_in(core[23:16]),
    .working_register(core[15:8]), .bank_select_register(core[7:0]),
    .restore_en(restore_en), .restore_status(rs), .restore_working(rw), .restore_bank(rb),
    .top_of_stack(top_w), .stack_fault_reset_enable(en), .pin_rst(ops[3]), .wdt_rst(ops[2]),
    .bor_rst(ops[1]), .inst_rst(ops[0]), .stack_reset_req(req), .stack_full_flag(full_f),
    .stack_underflow_flag(unf_f), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data compared in the cycle after its strobe; reset pulses counted
  always @(posedge sys_clk) begin
    if (rd_d) begin
      chk({16'h0, reg_rdata}, {16'h0, exp_q.pop_front()});
    end
    rd_d <= reg_re;
    if (req === 1'b1) reqs++;
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One operation pulse, tracked in the reference stack
  task automatic op(input logic [9:0] v, input logic f);
    seed = lfsr(seed);
    pc <= seed[20:0];
    ops <= v;
    fast <= f;
    if ((v[9] | v[7]) && stk.size() < 31) stk.push_back(seed[20:0]);
    if ((v[8] | v[6] | v[5]) && stk.size() > 0) void'(stk.pop_back());
    @(posedge sys_clk);
    ops <= 10'h000;
    fast <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic setcore;
    seed = lfsr(seed);
    sv = seed[23:0];
    nv <= sv;
    ld <= 1'b1;
    @(posedge sys_clk);
    ld <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdtos;
    chk({3'h0, top_w}, {3'h0, stk[$]});
    rd(4'h0, {3'h0, stk[$][20:16]});
    rd(4'h1, stk[$][15:8]);
    rd(4'h2, stk[$][7:0]);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    setcore();
    rd(4'h3, 8'h00);
    rd(4'h7, 8'h00);
    op(10'h200, 1'b0);
    op(10'h200, 1'b0);
    rdtos();
    wr(4'h0, 8'hff);
    wr(4'h1, 8'h3c);
    wr(4'h2, 8'h5a);
    stk[$] = 21'h1f3c5a;
    rdtos();
    op(10'h100, 1'b0);
    rdtos();
    op(10'h100, 1'b0);
    repeat (32) op(10'h200, 1'b0);
    chk(reqs, 0);
    rd(4'h3, 8'h9f);
    rdtos();
    rd(4'h4, 8'h01);
    wr(4'h5, 8'h03);
    chk(irq, 1'b1);
    wr(4'h4, 8'h01);
    chk(irq, 1'b0);
    repeat (31) op(10'h100, 1'b0);
    en <= 1'b1;
    op(10'h100, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk(reqs, 1);
    rd(4'h6, 8'h06);
    rd(4'h3, 8'hc0);
    chk({full_f, unf_f}, 2'b11);
    // Every other reset source, then all at once for priority
    op(10'h004, 1'b0);
    rd(4'h6, 8'h02);
    op(10'h008, 1'b0);
    rd(4'h6, 8'h01);
    op(10'h002, 1'b0);
    rd(4'h6, 8'h03);
    op(10'h001, 1'b0);
    rd(4'h6, 8'h04);
    op(10'h00f, 1'b0);
    rd(4'h6, 8'h01);
    rd(4'h3, 8'hc0);
    wr(4'h3, 8'hc0);
    rd(4'h3, 8'h00);
    en <= 1'b0;
    op(10'h200, 1'b0);
    setcore();
    op(10'h010, 1'b0);
    setcore();
    ev = sv;
    op(10'h010, 1'b0);
    setcore();
    op(10'h020, 1'b1);
    chk(core, ev);
    setcore();
    op(10'h200, 1'b0);
    op(10'h020, 1'b0);
    chk(core, sv);
    op(10'h080, 1'b1);
    ev = sv;
    setcore();
    op(10'h040, 1'b1);
    chk(core, ev);
    // Fast call and fast return back to back, core reloaded between
    setcore();
    ev = sv;
    seed = lfsr(seed);
    nv <= seed[23:0];
    ld <= 1'b1;
    ops <= 10'h080;
    fast <= 1'b1;
    @(posedge sys_clk);
    ld <= 1'b0;
    ops <= 10'h040;
    @(posedge sys_clk);
    ops <= 10'h000;
    fast <= 1'b0;
    @(posedge sys_clk);
    chk(core, ev);
    op(10'h100, 1'b0);
    rd(4'h3, 8'h40);
    // Full fault with reset enabled
    en <= 1'b1;
    repeat (32) op(10'h200, 1'b0);
    repeat (3) @(posedge sys_clk);
    stk.delete();
    chk(reqs, 2);
    rd(4'h6, 8'h05);
    rd(4'h3, 8'hc0);
    en <= 1'b0;
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(4'h3, 8'h00);
    rd(4'h6, 8'h00);
    chk({3'h0, top_w}, 24'h000000);
    wrap_up();
  end
endmodule // test_rss_top
